// *** verilog/asrx_rx.sv ***
// asynchronous serial receiver: oversampled start detection, majority
// voted bit recovery, parity and frame checks, buffered characters
// assumes sample_tick is a one-cycle enable at 16x baud (8x per bit in
// double speed the tick rate is the same, only fewer samples per bit)
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) parity computed over received data bits
// (R2) parity mismatch sets parity error flag
// (R3) receiver disable acts immediately
// (R4) disable flushes buffer, drops partial frame
// (R5) host flushes by reading data until empty
// (R6) sixteen samples per bit, eight double speed
// (R7) falling edge starts detection, sample one
// (R8) start vote samples 8-10 or 4-6
// (R9) two low votes accept and resynchronise
// (R10) two high votes reject start as noise
// (R11) resynchronise on every start bit
// (R12) each bit voted on three centre samples
// (R13) recover data, parity, first stop only
// (R14) low first stop bit sets frame error
// (R15) new start edge right after stop vote
// (R16) software picks lowest error baud settings
// (R17) error flags buffered with their character
// (R18) read status before data advances buffer
// (R19) second stop bit ignored
// (R20) even/odd parity expected bit definition
// (R21) start counter restarts after rejected start
module asrx_rx
  import asrx_pkg::*;
#(
  parameter int BUF_DEPTH = ASRX_BUF_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // sample enable from the baud generator
  input wire logic sample_tick,
  // serial line
  input wire logic rx_pin,
  // register port
  input wire logic [ASRX_AW-1:0] reg_addr,
  input wire logic [ASRX_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ASRX_DW-1:0] reg_rdata,
  // status
  output logic rx_complete_flag
);

  // configuration
  logic [ASRX_DW-1:0] ctrl_q;
  logic rx_enable;
  logic double_speed_select;
  logic parity_enable;
  logic parity_odd;
  logic [2:0] char_size;
  logic [3:0] last_bit;
  logic [4:0] spb;
  logic [4:0] vote_first;
  logic [4:0] vote_last;

  // line sampling
  logic rx_s1_q;
  logic rx_s2_q;
  logic samp_prev_q;
  logic [1:0] votes_q;
  logic vote_now;

  // frame recovery
  asrx_state_t state_q;
  logic [4:0] cnt_q;
  logic [3:0] bit_q;
  logic [8:0] shift_q;
  logic par_bit_q;
  logic par_expect;
  logic cnt_end;
  logic at_vote;

  // buffer
  logic frame_done;
  logic [ASRX_ENT_W-1:0] frame_entry;
  logic ovf_pend_q;
  logic buf_full;
  logic buf_empty;
  logic buf_pop;
  logic [ASRX_ENT_W-1:0] buf_head;
  logic frame_error_flag;
  logic parity_error_flag;
  logic rx_overflow_flag;

  // register outputs
  logic [ASRX_DW-1:0] rdata_q;
  logic rxc_q;

  function automatic logic maj3(input logic a, input logic b,
                                input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  assign rx_enable = ctrl_q[ASRX_CTRL_RXEN];
  assign double_speed_select = ctrl_q[ASRX_CTRL_DOUBLE];
  assign parity_enable = ctrl_q[ASRX_CTRL_PAREN];
  assign parity_odd = ctrl_q[ASRX_CTRL_PARODD];
  assign char_size = ctrl_q[ASRX_CTRL_CHSZ_HI:ASRX_CTRL_CHSZ_LO];

  // size codes above nine bits fall back to nine bits
  assign last_bit = (char_size > ASRX_CHSZ_9) ? ASRX_LAST_BIT_MAX :
                    ASRX_LAST_BIT_BASE + {1'b0, char_size};

  assign spb = double_speed_select ? ASRX_SPB_DOUBLE
                                   : ASRX_SPB_NORMAL; // [R6]
  assign vote_first = double_speed_select ? ASRX_VOTE_DOUBLE
                                          : ASRX_VOTE_NORMAL; // [R8]
  // cnt_q still holds the previous sample's number when a tick arrives,
  // so the third centre sample is met with cnt_q one below its number
  assign vote_last = vote_first + 5'h01;

  // third centre sample arrives now, the two before sit in votes_q
  assign vote_now = maj3(votes_q[1], votes_q[0], rx_s2_q); // [R12]
  assign at_vote = (cnt_q == vote_last);
  assign cnt_end = (cnt_q == spb);

  // unused high data bits are zero, so they do not disturb the parity
  assign par_expect = parity_odd ? ~^shift_q : ^shift_q; // [R1] [R20]

  assign frame_done = rx_enable && sample_tick &&
                      (state_q == ASRX_STOP) && at_vote; // [R13]

  assign frame_entry[8:0] = shift_q;
  assign frame_entry[ASRX_ENT_PARITY_ERROR_FLAG] = parity_enable &&
                                      (par_bit_q != par_expect); // [R2]
  assign frame_entry[ASRX_ENT_FRAME_ERROR_FLAG] = !vote_now; // [R14]
  assign frame_entry[ASRX_ENT_OVF] = ovf_pend_q;

  assign frame_error_flag = !buf_empty && buf_head[ASRX_ENT_FRAME_ERROR_FLAG];
  assign parity_error_flag = !buf_empty && buf_head[ASRX_ENT_PARITY_ERROR_FLAG];
  assign rx_overflow_flag = !buf_empty && buf_head[ASRX_ENT_OVF];

  // reading the data location advances the buffer
  assign buf_pop = reg_rd && (reg_addr == ASRX_ADDR_DATA); // [R18]

  assign reg_rdata = rdata_q;
  assign rx_complete_flag = rxc_q;

  // two-flop synchroniser on the pin; only rx_s2_q is used further on
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  // line level seen at each sample, for edge and vote history
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      samp_prev_q <= 1'b1;
      votes_q <= 2'h3;
    end else if (sample_tick) begin
      samp_prev_q <= rx_s2_q;
      votes_q <= {votes_q[0], rx_s2_q};
    end
  end

  // control register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= ASRX_CTRL_RST;
    end else if (reg_wr && (reg_addr == ASRX_ADDR_CTRL)) begin
      ctrl_q <= reg_wdata;
    end
  end

  // frame sequencer
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ASRX_IDLE;
      cnt_q <= '0;
      bit_q <= '0;
    end else if (!rx_enable) begin
      // abandon any frame at once, nothing is stored
      state_q <= ASRX_IDLE; // [R3] [R4]
      cnt_q <= '0;
      bit_q <= '0;
    end else if (sample_tick) begin
      case (state_q)
        ASRX_IDLE: begin
          // only a high-to-low step on the line starts a frame
          if (samp_prev_q && !rx_s2_q) begin
            state_q <= ASRX_START; // [R7]
            cnt_q <= ASRX_CNT_FIRST;
          end
        end
        ASRX_START: begin
          if (at_vote) begin
            if (!vote_now) begin
              // bit timing now counts from this start edge
              state_q <= ASRX_ALIGN; // [R9] [R11]
              cnt_q <= cnt_q + 5'h01;
            end else begin
              state_q <= ASRX_IDLE; // [R10]
              cnt_q <= '0; // [R21]
            end
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ASRX_ALIGN: begin
          // run out the rest of the start bit
          if (cnt_end) begin
            state_q <= ASRX_DATA;
            cnt_q <= ASRX_CNT_FIRST;
            bit_q <= '0;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ASRX_DATA: begin
          if (cnt_end) begin
            cnt_q <= ASRX_CNT_FIRST; // [R12]
            if (bit_q == last_bit) begin
              bit_q <= '0;
              state_q <= parity_enable ? ASRX_PARITY : ASRX_STOP;
            end else begin
              bit_q <= bit_q + 4'h1;
            end
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ASRX_PARITY: begin
          if (cnt_end) begin
            cnt_q <= ASRX_CNT_FIRST;
            state_q <= ASRX_STOP;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ASRX_STOP: begin
          // no wait for the stop bit end; any second stop is not sampled
          if (at_vote) begin
            state_q <= ASRX_IDLE; // [R15] [R19]
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        default: begin
          state_q <= ASRX_IDLE;
          cnt_q <= '0;
          bit_q <= '0;
        end
      endcase
    end
  end

  // data and parity capture
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      shift_q <= '0;
      par_bit_q <= 1'b0;
    end else if (rx_enable && sample_tick) begin
      if (state_q == ASRX_START && at_vote) begin
        shift_q <= '0;
        par_bit_q <= 1'b0;
      end else if (state_q == ASRX_DATA && at_vote) begin
        shift_q[bit_q] <= vote_now; // [R12]
      end else if (state_q == ASRX_PARITY && at_vote) begin
        par_bit_q <= vote_now; // [R1]
      end
    end
  end

  // a frame that finds the buffer full is lost; the next one stored
  // carries the overflow mark
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ovf_pend_q <= 1'b0;
    end else if (!rx_enable) begin
      ovf_pend_q <= 1'b0; // [R4]
    end else if (frame_done) begin
      ovf_pend_q <= buf_full && !buf_pop;
    end
  end

  // flags travel in the buffer with their character
  asrx_fifo #(
    .WIDTH(ASRX_ENT_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .flush(!rx_enable), // [R4]
    .push(frame_done), // [R17]
    .push_data(frame_entry),
    .pop(buf_pop), // [R5]
    .full(buf_full),
    .empty(buf_empty),
    .head(buf_head)
  );

  // read data, valid the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ASRX_ADDR_CTRL: begin
          rdata_q <= ctrl_q;
        end
        ASRX_ADDR_STATUS: begin
          rdata_q <= '0;
          rdata_q[ASRX_ST_RXC] <= !buf_empty;
          rdata_q[ASRX_ST_FRAME_ERROR_FLAG] <= frame_error_flag; // [R17]
          rdata_q[ASRX_ST_OVF] <= rx_overflow_flag;
          rdata_q[ASRX_ST_PARITY_ERROR_FLAG] <= parity_error_flag;
          rdata_q[ASRX_ST_RXB8] <= !buf_empty && buf_head[8];
        end
        ASRX_ADDR_DATA: begin
          // an empty buffer reads as zero and is not advanced
          rdata_q <= buf_empty ? '0 : buf_head[7:0];
        end
        default: begin
          rdata_q <= '0;
        end
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // registered copy of the receive complete state
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxc_q <= 1'b0;
    end else begin
      rxc_q <= !buf_empty;
    end
  end

endmodule
`default_nettype wire

// *** verilog/asrx_pkg.sv ***
// constants for the asynchronous serial receive path
// assumes one peripheral clock and an external sample tick generator
`default_nettype none
package asrx_pkg;

  // register port
  localparam int ASRX_AW = 2;
  localparam int ASRX_DW = 8;
  localparam logic [1:0] ASRX_ADDR_CTRL = 2'h0;
  localparam logic [1:0] ASRX_ADDR_STATUS = 2'h1;
  localparam logic [1:0] ASRX_ADDR_DATA = 2'h2;

  // control register fields
  localparam int ASRX_CTRL_RXEN = 0;
  localparam int ASRX_CTRL_DOUBLE = 1;
  localparam int ASRX_CTRL_PAREN = 2;
  localparam int ASRX_CTRL_PARODD = 3;
  localparam int ASRX_CTRL_CHSZ_LO = 4;
  localparam int ASRX_CTRL_CHSZ_HI = 6;
  localparam int ASRX_CTRL_STOP2 = 7;
  localparam logic [7:0] ASRX_CTRL_RST = 8'h30;

  // status register fields
  localparam int ASRX_ST_RXB8 = 0;
  localparam int ASRX_ST_PARITY_ERROR_FLAG = 2;
  localparam int ASRX_ST_OVF = 3;
  localparam int ASRX_ST_FRAME_ERROR_FLAG = 4;
  localparam int ASRX_ST_RXC = 7;

  // character size code: 0..4 mean 5..9 data bits
  localparam logic [2:0] ASRX_CHSZ_9 = 3'h4;
  localparam logic [3:0] ASRX_LAST_BIT_BASE = 4'h4;
  localparam logic [3:0] ASRX_LAST_BIT_MAX = 4'h8;

  // buffered entry layout: data, then parity, overflow, frame flags
  localparam int ASRX_ENT_W = 12;
  localparam int ASRX_ENT_PARITY_ERROR_FLAG = 9;
  localparam int ASRX_ENT_OVF = 10;
  localparam int ASRX_ENT_FRAME_ERROR_FLAG = 11;
  localparam int ASRX_BUF_DEPTH = 2;

  // oversampling: samples per bit and first voting sample
  localparam logic [4:0] ASRX_SPB_NORMAL = 5'h10;
  localparam logic [4:0] ASRX_SPB_DOUBLE = 5'h08;
  localparam logic [4:0] ASRX_VOTE_NORMAL = 5'h08;
  localparam logic [4:0] ASRX_VOTE_DOUBLE = 5'h04;
  localparam logic [4:0] ASRX_CNT_FIRST = 5'h01;

  typedef enum logic [2:0] {
    ASRX_IDLE,
    ASRX_START,
    ASRX_ALIGN,
    ASRX_DATA,
    ASRX_PARITY,
    ASRX_STOP
  } asrx_state_t;

endpackage
`default_nettype wire

// *** verilog/asrx_fifo.sv ***
// small receive buffer holding characters with their error flags
// a push that finds it full is dropped unless a pop happens in the same cycle
`timescale 1ns/1ps
`default_nettype none
module asrx_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // control
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  // state
  output logic full,
  output logic empty,
  output logic [WIDTH-1:0] head
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic do_push;
  logic do_pop;

  assign empty = (cnt_q == '0);
  assign full = (cnt_q == CNT_FULL);
  assign head = mem_q[rd_q];
  assign do_pop = pop && !empty;
  assign do_push = push && (!full || do_pop);

  always_ff @(posedge ref_clk) begin
    if (do_push && !flush) begin
      mem_q[wr_q] <= push_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// *** testbench/asrx_rx_sva.sv ***
// port checker for the serial receive path, bound into asrx_rx
// assumes one clock domain and the register port timing of the block
`timescale 1ns/1ps
`default_nettype none
module asrx_rx_sva
  import asrx_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // serial side
  input wire logic sample_tick,
  input wire logic rx_pin,
  // register port
  input wire logic [ASRX_AW-1:0] reg_addr,
  input wire logic [ASRX_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ASRX_DW-1:0] reg_rdata,
  input wire logic rx_complete_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  logic [1:0] dis_cnt_q;
  logic [7:0] idle_cnt_q;
  logic off_wr;
  logic drain;
  assign off_wr = reg_wr && reg_addr == ASRX_ADDR_CTRL &&
                  !reg_wdata[ASRX_CTRL_RXEN];
  assign drain = reg_rd && reg_addr == ASRX_ADDR_DATA;

  // edges since the receiver was switched off, saturating at 3
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dis_cnt_q <= 2'h3;
    end else if (reg_wr && reg_addr == ASRX_ADDR_CTRL) begin
      dis_cnt_q <= reg_wdata[ASRX_CTRL_RXEN] ? 2'h0 : 2'h1;
    end else if (dis_cnt_q != 2'h0 && dis_cnt_q != 2'h3) begin
      dis_cnt_q <= dis_cnt_q + 2'h1;
    end
  end

  // ticks with the raw line high; longer than any frame means no push
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      idle_cnt_q <= 8'h00;
    end else if (sample_tick) begin
      if (!rx_pin) begin
        idle_cnt_q <= 8'h00;
      end else if (idle_cnt_q != 8'hFF) begin
        idle_cnt_q <= idle_cnt_q + 8'h01;
      end
    end
  end

  property p_off_quiet;
    dis_cnt_q == 2'h3 |-> !rx_complete_flag;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("flag set while receiver is off");
  property p_off_flush;
    off_wr |-> ##3 !rx_complete_flag;
  endproperty
  a_off_flush: assert property (p_off_flush)
    else $error("buffer not flushed three cycles after disable");
  property p_empty_data;
    reg_rd && reg_addr == ASRX_ADDR_DATA && dis_cnt_q == 2'h3
      |=> reg_rdata == 8'h00;
  endproperty
  a_empty_data: assert property (p_empty_data)
    else $error("data read of empty buffer not zero");
  property p_empty_status;
    reg_rd && reg_addr == ASRX_ADDR_STATUS && dis_cnt_q == 2'h3
      |=> reg_rdata == 8'h00;
  endproperty
  a_empty_status: assert property (p_empty_status)
    else $error("status of empty buffer not zero");
  property p_push_on_tick;
    $rose(rx_complete_flag) |-> $past(sample_tick, 2);
  endproperty
  a_push_on_tick: assert property (p_push_on_tick)
    else $error("character stored away from a sample tick");
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero without a read");
  property p_fall_cause;
    $fell(rx_complete_flag) |-> $past(drain, 2) || $past(off_wr, 3);
  endproperty
  a_fall_cause: assert property (p_fall_cause)
    else $error("flag fell without a data read or disable");
  property p_no_start;
    idle_cnt_q >= 8'hC8 |-> !$rose(rx_complete_flag);
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("character stored without a start edge");

  c_rx_done: cover property ($rose(rx_complete_flag));
  c_off_full: cover property (off_wr && rx_complete_flag);
  c_status_rd: cover property (reg_rd && reg_addr == ASRX_ADDR_STATUS &&
                               rx_complete_flag);
endmodule

bind asrx_rx asrx_rx_sva u_asrx_rx_sva (.ref_clk(ref_clk), .rstn(rstn),
  .sample_tick(sample_tick), .rx_pin(rx_pin), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_complete_flag(rx_complete_flag));
`default_nettype wire

// *** testbench/asrx_tx_model.sv ***
// far-end transmitter model driving the receive line
// assumes sample_tick pulses in the ref_clk domain; times are in ticks
`timescale 1ns/1ps
`default_nettype none
module asrx_tx_model (
  // clock and tick
  input wire logic ref_clk,
  input wire logic sample_tick,
  // serial line, idles high
  output logic rx_line
);
  initial rx_line = 1'b1;
  // time of the last tick edge on which a hold ended
  time edge_t = 0;

  // drive a level for n ticks; changes land just after a tick edge
  task automatic hold(input logic v, input int n);
    rx_line <= v;
    repeat (n) begin
      do @(posedge ref_clk); while (sample_tick !== 1'b1);
    end
    edge_t = $time;
  endtask

  // pm: 0 none, 1 even, 2 odd; bad flips the parity bit on request
  task automatic send(input logic [8:0] d, input int nb, input int spb,
      input int pm, input logic bad, input logic sv, input int sn);
    logic p;
    p = ^(d & ((9'h001 << nb) - 9'h001));
    if (pm == 2) p = ~p;
    // a start launched off a tick edge would look one sample short
    if ($time != edge_t) begin
      do @(posedge ref_clk); while (sample_tick !== 1'b1);
    end
    hold(1'b0, spb);
    for (int i = 0; i < nb; i++) hold(d[i], spb);
    if (pm != 0) hold(p ^ bad, spb);
    // line stays at the stop level; caller restores idle after a bad stop
    hold(sv, sn);
  endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the serial receive path
// assumes the transmitter model owns rx_pin and the bench owns the ticks
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import asrx_pkg::*;
  logic ref_clk, rstn, sample_tick, reg_wr, reg_rd, rx_complete_flag;
  logic [ASRX_AW-1:0] reg_addr;
  logic [ASRX_DW-1:0] reg_wdata, reg_rdata, rv;
  logic [1:0] tdiv;
  wire rx_pin;
  int mismatches, comparisons, cycles;

  asrx_rx u_asrx_rx (.ref_clk(ref_clk), .rstn(rstn),
    .sample_tick(sample_tick), .rx_pin(rx_pin), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_complete_flag(rx_complete_flag));
  asrx_tx_model u_asrx_tx_model (.ref_clk(ref_clk),
    .sample_tick(sample_tick), .rx_line(rx_pin));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // one sample tick every fourth clock, exactly the model's rate
  always @(posedge ref_clk) begin
    tdiv <= tdiv + 2'h1;
    sample_tick <= (tdiv == 2'h3);
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // status is read before data, since the data read pops the entry
  task automatic got(input logic [7:0] st, input logic [7:0] d);
    for (int n = 0; n < 4000 && rx_complete_flag !== 1'b1; n++) begin
      @(posedge ref_clk);
    end
    rd(ASRX_ADDR_STATUS, rv);
    chk("status", rv, st);
    rd(ASRX_ADDR_DATA, rv);
    chk("data", rv, d);
  endtask

  function automatic logic [7:0] ctl(input logic dbl, par, odd,
      input logic [2:0] cs, input logic s2);
    ctl = 8'h00;
    ctl[ASRX_CTRL_RXEN] = 1'b1;
    ctl[ASRX_CTRL_DOUBLE] = dbl;
    ctl[ASRX_CTRL_PAREN] = par;
    ctl[ASRX_CTRL_PARODD] = odd;
    ctl[ASRX_CTRL_CHSZ_HI:ASRX_CTRL_CHSZ_LO] = cs;
    ctl[ASRX_CTRL_STOP2] = s2;
  endfunction

  task automatic tx(input logic [8:0] d, input int nb, spb, pm,
      input logic bad, sv, input int sn);
    u_asrx_tx_model.send(d, nb, spb, pm, bad, sv, sn);
  endtask

  initial begin
    {rstn, sample_tick, reg_wr, reg_rd, tdiv} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    {mismatches, comparisons, cycles} = '0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(2'h3, rv);
    chk("unmapped", rv, 8'h00);
    rd(ASRX_ADDR_DATA, rv);
    chk("empty", rv, 8'h00);
    wr(ASRX_ADDR_CTRL, ctl(0, 0, 0, 3'h3, 0));
    tx(9'h0A5, 8, 16, 0, 0, 1, 16);
    got(8'h80, 8'hA5);
    for (int m = 1; m < 3; m++) begin
      for (int b = 0; b < 2; b++) begin
        wr(ASRX_ADDR_CTRL, ctl(0, 1, m == 2, 3'h3, 0));
        tx(9'h0C2 + 9'(m), 8, 16, m, b[0], 1, 16);
        got(b[0] ? 8'h84 : 8'h80, 8'hC2 + 8'(m));
      end
    end
    for (int c = 0; c < 5; c++) begin
      wr(ASRX_ADDR_CTRL, ctl(0, 0, 0, 3'(c), 0));
      tx(9'h15A, 5 + c, 16, 0, 0, 1, 16);
      got(c == 4 ? 8'h81 : 8'h80,
          8'(9'h15A & ((9'h001 << (5 + c)) - 9'h001)));
    end
    wr(ASRX_ADDR_CTRL, ctl(1, 0, 0, 3'h3, 0));
    tx(9'h03C, 8, 8, 0, 0, 1, 8);
    got(8'h80, 8'h3C);
    wr(ASRX_ADDR_CTRL, ctl(0, 0, 0, 3'h3, 0));
    tx(9'h055, 8, 16, 0, 0, 0, 16);
    u_asrx_tx_model.hold(1'b1, 20);
    got(8'h90, 8'h55);
    // low for samples 1..8 only: one low vote, rejected as noise
    u_asrx_tx_model.hold(1'b0, 8);
    // long idle so the no-start check sees a quiet line
    u_asrx_tx_model.hold(1'b1, 220);
    tx(9'h096, 8, 16, 0, 0, 1, 16);
    got(8'h80, 8'h96);
    rd(ASRX_ADDR_DATA, rv);
    chk("one entry", rv, 8'h00);
    // stop cut short after its last vote, third frame overflows
    wr(ASRX_ADDR_CTRL, ctl(0, 0, 0, 3'h3, 1));
    for (int i = 0; i < 3; i++) tx(9'h011 + 9'(i), 8, 16, 0, 0, 1, 10);
    u_asrx_tx_model.hold(1'b1, 20);
    got(8'h80, 8'h11);
    got(8'h80, 8'h12);
    repeat (2) @(posedge ref_clk);
    chk("drained", {7'h00, rx_complete_flag}, 8'h00);
    tx(9'h077, 8, 16, 0, 0, 1, 16);
    got(8'h88, 8'h77);
    tx(9'h0E1, 8, 16, 0, 0, 1, 16);
    fork
      tx(9'h0F0, 8, 16, 0, 0, 1, 16);
      begin
        repeat (300) @(posedge ref_clk);
        wr(ASRX_ADDR_CTRL, ASRX_CTRL_RST);
      end
    join
    chk("flushed", {7'h00, rx_complete_flag}, 8'h00);
    rd(ASRX_ADDR_STATUS, rv);
    chk("off status", rv, 8'h00);
    wr(ASRX_ADDR_CTRL, ctl(0, 0, 0, 3'h3, 0));
    tx(9'h05B, 8, 16, 0, 0, 1, 16);
    got(8'h80, 8'h5B);
    wrap_up();
  end
endmodule
`default_nettype wire
